// ### rlcs_host.sv
// Host-side model that sends frames over the link
`timescale 1ns/10ps
module rlcs_host (
    input  wire logic i_ref_clk,
    output logic      o_rx_frame,
    output logic      o_rx_error
);
    // Link idle until the bench asks for a frame
    initial begin
        o_rx_frame = 1'b0;
        o_rx_error = 1'b0;
    end
    // Gap picks a prompt or slow host; frame seen as one level pulse
    task automatic send(input int gap);
        repeat (gap) @(posedge i_ref_clk);
        o_rx_frame <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_rx_frame <= 1'b0;
    endtask
endmodule // rlcs_host

// ### rlcs_nvstore.sv
// Nonvolatile shadow of the settings with write-through selection
`timescale 1ns/10ps
module rlcs_nvstore (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_power_up,
    input  wire logic              i_we,
    input  wire logic [3:0]        i_idx,
    input  wire logic [15:0]       i_data,
    input  wire logic              i_ram_only,
    output logic                   o_nv_wr,
    output logic [15:0]            o_nv_word [0:10]
);
    import rlcs_pkg::*;

    // Nonvolatile words survive reset and power cycles
    logic [15:0] nv_mem [0:10];
    logic        nv_fmt;           // Set once the store holds data

    // RQ19: write-through unless RAM-only
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_nv_wr <= 1'b0;
        end else begin
            o_nv_wr <= i_we && !i_ram_only;
        end
    end

    // Storage array; host writes land only in EEPROM+RAM mode, blank-store init at power-up in any mode
    always_ff @(posedge i_ref_clk) begin
        if (i_power_up && nv_fmt == 1'b1) begin
            nv_fmt     <= 1'b1;
        end else if (i_power_up) begin
            // Blank store takes the initial values once
            nv_fmt     <= 1'b1;
            nv_mem[0]  <= INIT_STATION;
            nv_mem[1]  <= INIT_SPEED;
            nv_mem[2]  <= INIT_CHARFMT;
            nv_mem[3]  <= INIT_PARITY;
            nv_mem[4]  <= INIT_RETRY;
            nv_mem[5]  <= INIT_CHECK;
            nv_mem[6]  <= INIT_WAIT;
            nv_mem[7]  <= INIT_TERM;
            nv_mem[8]  <= INIT_NVSEL;
            nv_mem[9]  <= INIT_PROTO;
            nv_mem[10] <= INIT_UGROUP;
        end else if (i_we && !i_ram_only && i_idx <= 4'hA) begin
            nv_mem[i_idx] <= i_data;
        end
    end

    assign o_nv_word = nv_mem;

endmodule // rlcs_nvstore

// ### rlcs_pkg.sv
// Package for the RS-485 link configuration and store block
package rlcs_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_STATION   = 4'h0;
    localparam logic [3:0] ADDR_SPEED     = 4'h1;
    localparam logic [3:0] ADDR_CHARFMT   = 4'h2;
    localparam logic [3:0] ADDR_PARITY    = 4'h3;
    localparam logic [3:0] ADDR_RETRY     = 4'h4;
    localparam logic [3:0] ADDR_CHECK     = 4'h5;
    localparam logic [3:0] ADDR_WAIT      = 4'h6;
    localparam logic [3:0] ADDR_TERM      = 4'h7;
    localparam logic [3:0] ADDR_NVSEL     = 4'h8;
    localparam logic [3:0] ADDR_PROTO     = 4'h9;
    localparam logic [3:0] ADDR_UGROUP    = 4'hA;
    localparam logic [3:0] ADDR_STATUS    = 4'hB;
    localparam logic [3:0] ADDR_ACTIVE_A  = 4'hC;
    localparam logic [3:0] ADDR_ACTIVE_B  = 4'hD;

    // Special "unused / disabled" setting value
    localparam logic [15:0] VAL_9999      = 16'h270F;

    // Initial setting values
    localparam logic [15:0] INIT_STATION  = 16'h0000;
    localparam logic [15:0] INIT_SPEED    = 16'h0060;
    localparam logic [15:0] INIT_CHARFMT  = 16'h0001;
    localparam logic [15:0] INIT_PARITY   = 16'h0002;
    localparam logic [15:0] INIT_RETRY    = 16'h0001;
    localparam logic [15:0] INIT_CHECK    = 16'h0000;
    localparam logic [15:0] INIT_WAIT     = 16'h270F;
    localparam logic [15:0] INIT_TERM     = 16'h0001;
    localparam logic [15:0] INIT_NVSEL    = 16'h0000;
    localparam logic [15:0] INIT_PROTO    = 16'h0000;
    localparam logic [15:0] INIT_UGROUP   = 16'h0000;

    // Legal limits
    localparam logic [15:0] MAX_STN_NAT   = 16'h001F;
    localparam logic [15:0] MAX_STN_MB    = 16'h00F7;
    localparam logic [15:0] MAX_RETRY     = 16'h000A;
    localparam logic [15:0] MIN_CHECK     = 16'h0001;
    localparam logic [15:0] MAX_CHECK     = 16'h270E;
    localparam logic [15:0] MAX_WAIT      = 16'h0096;
    localparam logic [15:0] MAX_TRI       = 16'h0002;
    localparam logic [15:0] CF_10         = 16'h000A;
    localparam logic [15:0] CF_11         = 16'h000B;

    // Modbus data length in bits
    localparam logic [3:0]  MB_DATA_BITS  = 4'h8;

    // Terminator codes
    localparam logic [1:0]  TERM_NONE     = 2'h0;
    localparam logic [1:0]  TERM_CR       = 2'h1;
    localparam logic [1:0]  TERM_CRLF     = 2'h2;

    // Speed code to a small index
    typedef enum logic [2:0] {
        RLCS_SPD_3   = 3'h0,
        RLCS_SPD_6   = 3'h1,
        RLCS_SPD_12  = 3'h2,
        RLCS_SPD_24  = 3'h3,
        RLCS_SPD_48  = 3'h4,
        RLCS_SPD_96  = 3'h5,
        RLCS_SPD_192 = 3'h6,
        RLCS_SPD_384 = 3'h7
    } rlcs_speed_e;

    // Supervisor states, Gray along idle->wait->run->trip
    typedef enum logic [1:0] {
        RLCS_IDLE = 2'b00,
        RLCS_WAIT = 2'b01,
        RLCS_RUN  = 2'b11,
        RLCS_TRIP = 2'b10
    } rlcs_state_e;

    // Effective link settings after reset
    typedef struct packed {
        logic [7:0]  station;
        rlcs_speed_e speed;
        logic [3:0]  data_bits;
        logic [1:0]  stop_bits;
        logic [1:0]  parity;
        logic        retry_off;
        logic [3:0]  retry;
        logic        check_off;
        logic        check_zero;
        logic [15:0] check_tenths;
        logic        wait_off;
        logic [7:0]  wait_ms;
        logic [1:0]  term;
        logic        modbus;
    } rlcs_cfg_s;

endpackage : rlcs_pkg

// ### rlcs_top.sv
// RS-485 link configuration, store selection and link supervisor
// How it works
// RQ1: station 0..31 native, 0..247 Modbus
// RQ2: speed codes 3..384, default 96
// RQ3: one format setting 0,1,10,11, default 1
// RQ4: parity options 0..2, default 2
// RQ5: retry 0..10 or 9999, default 1
// RQ6: interval 0 serves, trips in network mode
// RQ7: check interval 0.1..999.8 s, 9999 off
// RQ8: response wait 0..150 ms or 9999
// RQ9: terminator setting 0..2, default 1
// RQ10: 0 none, 1 CR, 2 CR LF
// RQ11: protocol 0 native, 1 Modbus
// RQ12: Modbus eight data bits, parity stop
// RQ13: Modbus ignores native-only settings
// RQ14: Modbus only on RS-485 terminal port
// RQ15: illegal value acts as initial value
// RQ16: changes apply only after reset
// RQ17: network power-up, interval 0, first traffic trips
// RQ18: host should set interval 9999 first
// RQ19: store select 0 NV+RAM, 1 RAM
// RQ20: RAM-only writes lost at power-off
// RQ21: settings writable when user group is 0
// RQ22: store select writable with option present
`timescale 1ns/10ps
module rlcs_top (
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst_b,
    input  wire logic                i_power_up,
    input  wire logic [3:0]          i_addr,
    input  wire logic [15:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [15:0]              o_rdata,
    input  wire logic                i_option_present,
    input  wire logic                i_net_mode,
    input  wire logic                i_port_is_rs485,
    input  wire logic                i_rx_frame,
    input  wire logic                i_rx_error,
    output rlcs_pkg::rlcs_cfg_s      o_cfg,
    output logic                     o_modbus_active,
    output logic                     o_link_ready,
    output logic                     o_comm_fault_trip,
    output logic                     o_nv_wr,
    output logic                     o_tick_100ms
);
    import rlcs_pkg::*;

    // Timing
    localparam int unsigned CLK_HZ       = 125000000;
    localparam int unsigned TICK_MS      = 100;
    localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;

    // Synchronised pin-level inputs
    logic [1:0]  net_sync;         // Network mode sync
    logic [1:0]  frm_sync;         // Frame strobe sync
    logic [1:0]  err_sync;         // Receive error sync
    logic [1:0]  opt_sync;         // Option present sync
    logic        frm_last;         // Edge history of frame
    logic        err_last;         // Edge history of error
    logic        frame_ev;         // One-cycle frame event
    logic        error_ev;         // One-cycle error event

    // Software setting words (RAM copy)
    logic [15:0] ram_word [0:10];
    logic [15:0] nv_word  [0:10];
    logic        wr_ok;            // Write permitted this cycle
    logic        wr_hit;           // Write to a setting register

    // Applied state
    rlcs_cfg_s   cfg_new;          // Validation of the RAM copy
    rlcs_cfg_s   cfg_act;          // Latched at reset release
    logic        loaded;           // Settings applied since reset
    logic        changed;          // Setting changed since apply
    logic        boot_net;         // Network mode seen at boot

    // Supervisor
    rlcs_state_e state;
    rlcs_state_e next_state;
    logic [23:0] tick_cnt;
    logic [15:0] idle_tenths;      // Tenths of a second with no frame
    logic [3:0]  retry_cnt;
    logic        first_frame;

    // Mode sync runs through reset; boot mode known at release
    always_ff @(posedge i_ref_clk) begin
        net_sync <= {net_sync[0], i_net_mode};
    end

    // Two-flop synchronisers for pin inputs
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frm_sync <= 2'b00;
            err_sync <= 2'b00;
            opt_sync <= 2'b00;
        end else begin
            frm_sync <= {frm_sync[0], i_rx_frame};
            err_sync <= {err_sync[0], i_rx_error};
            opt_sync <= {opt_sync[0], i_option_present};
        end
    end

    // Rising edges from the second stage only
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frm_last <= 1'b0;
            err_last <= 1'b0;
        end else begin
            frm_last <= frm_sync[1];
            err_last <= err_sync[1];
        end
    end

    assign frame_ev = frm_sync[1] && !frm_last;
    assign error_ev = err_sync[1] && !err_last;

    // RQ21: settings locked unless group is 0
    // RQ22: store select writable with option
    always_comb begin
        wr_hit = i_wr && (i_addr <= ADDR_UGROUP);
        if (i_addr == ADDR_NVSEL) begin
            wr_ok = (ram_word[ADDR_UGROUP] == 16'h0000) || opt_sync[1];
        end else if (i_addr == ADDR_UGROUP) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = (ram_word[ADDR_UGROUP] == 16'h0000);
        end
    end

    // RAM copy of the settings
    // RQ20: power-up restores nonvolatile values
    always_ff @(posedge i_ref_clk) begin
        if (i_power_up) begin
            for (int k = 0; k <= 10; k++) begin
                ram_word[k] <= nv_word[k];
            end
        end else if (wr_hit && wr_ok) begin
            ram_word[i_addr] <= i_wdata;
        end
    end

    // Nonvolatile store behind the RAM copy
    rlcs_nvstore u_nv (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (i_rst_b),
        .i_power_up (i_power_up),
        .i_we       (wr_hit && wr_ok),
        .i_idx      (i_addr),
        .i_data     (i_wdata),
        .i_ram_only (ram_word[ADDR_NVSEL] == 16'h0001),
        .o_nv_wr    (o_nv_wr),
        .o_nv_word  (nv_word)
    );

    // Range check of the RAM copy
    rlcs_validate u_val (
        .i_station (ram_word[ADDR_STATION]),
        .i_speed   (ram_word[ADDR_SPEED]),
        .i_charfmt (ram_word[ADDR_CHARFMT]),
        .i_parity  (ram_word[ADDR_PARITY]),
        .i_retry   (ram_word[ADDR_RETRY]),
        .i_check   (ram_word[ADDR_CHECK]),
        .i_wait    (ram_word[ADDR_WAIT]),
        .i_term    (ram_word[ADDR_TERM]),
        .i_proto   (ram_word[ADDR_PROTO]),
        .o_cfg     (cfg_new)
    );

    // RQ16: apply once after reset release
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_act  <= '0;
            loaded   <= 1'b0;
            boot_net <= 1'b0;
        end else if (!loaded && !i_power_up) begin
            cfg_act  <= cfg_new;
            loaded   <= 1'b1;
            boot_net <= net_sync[1];
        end
    end

    // RQ16: any link setting change blocks link
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            changed <= 1'b0;
        end else if (loaded && wr_hit && wr_ok && i_addr != ADDR_NVSEL
                     && i_addr != ADDR_UGROUP) begin
            changed <= 1'b1;
        end
    end

    assign o_cfg           = cfg_act;
    // RQ14: Modbus only on RS-485 port
    assign o_modbus_active = cfg_act.modbus && i_port_is_rs485;
    assign o_link_ready    = loaded && !changed && (state != RLCS_TRIP);

    // 100 ms timebase for the loss check
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt     <= 24'h000000;
            o_tick_100ms <= 1'b0;
        end else if (tick_cnt == 24'(TICK_CYC - 1)) begin
            tick_cnt     <= 24'h000000;
            o_tick_100ms <= 1'b1;
        end else begin
            tick_cnt     <= tick_cnt + 24'h000001;
            o_tick_100ms <= 1'b0;
        end
    end

    // Supervisor next state
    always_comb begin
        next_state = state;
        case (state)
            RLCS_IDLE: begin
                if (loaded) begin
                    next_state = RLCS_WAIT;
                end
            end
            RLCS_WAIT: begin
                // RQ17: boot in network, interval 0
                if (frame_ev && cfg_act.check_zero && boot_net) begin
                    next_state = RLCS_TRIP;
                end else if (frame_ev) begin
                    next_state = RLCS_RUN;
                end
            end
            RLCS_RUN: begin
                // RQ6: interval 0 trips in network mode
                if (cfg_act.check_zero && net_sync[1]) begin
                    next_state = RLCS_TRIP;
                // RQ7: loss check unless disabled
                end else if (!cfg_act.check_off && !cfg_act.check_zero
                             && idle_tenths >= cfg_act.check_tenths && net_sync[1]) begin
                    next_state = RLCS_TRIP;
                // RQ5: retry limit exceeded
                end else if (error_ev && !cfg_act.retry_off
                             && retry_cnt >= cfg_act.retry && net_sync[1]) begin
                    next_state = RLCS_TRIP;
                end
            end
            RLCS_TRIP: begin
                next_state = RLCS_TRIP;
            end
            default: begin
                next_state = RLCS_IDLE;
            end
        endcase
    end

    // Supervisor state; trip holds until reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= RLCS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Idle time since last frame, in tenths
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idle_tenths <= 16'h0000;
        end else if (frame_ev || state != RLCS_RUN) begin
            idle_tenths <= 16'h0000;
        end else if (o_tick_100ms && idle_tenths != 16'hFFFF) begin
            idle_tenths <= idle_tenths + 16'h0001;
        end
    end

    // Consecutive receive error count
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            retry_cnt   <= 4'h0;
            first_frame <= 1'b0;
        end else if (frame_ev && !error_ev) begin
            retry_cnt   <= 4'h0;
            first_frame <= 1'b1;
        end else if (error_ev && retry_cnt != 4'hF) begin
            retry_cnt   <= retry_cnt + 4'h1;
        end
    end

    assign o_comm_fault_trip = (state == RLCS_TRIP);

    // Registered read port
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else if (i_rd && i_addr <= ADDR_UGROUP) begin
            o_rdata <= ram_word[i_addr];
        end else if (i_rd && i_addr == ADDR_STATUS) begin
            o_rdata <= {9'h000, first_frame, changed, loaded,
                        o_comm_fault_trip, cfg_act.modbus, state};
        end else if (i_rd && i_addr == ADDR_ACTIVE_A) begin
            o_rdata <= {cfg_act.station, 1'b0, cfg_act.speed, cfg_act.term, cfg_act.parity};
        end else if (i_rd && i_addr == ADDR_ACTIVE_B) begin
            o_rdata <= {8'h00, cfg_act.data_bits, cfg_act.stop_bits,
                        cfg_act.wait_off, cfg_act.check_off};
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule // rlcs_top

// ### rlcs_top_chk.sv
// Port-level assertions for the link configuration block
`timescale 1ns/10ps
module rlcs_top_chk
    import rlcs_pkg::*;
(
    input wire logic                i_ref_clk,
    input wire logic                i_rst_b,
    input wire logic                i_wr,
    input wire logic                i_port_is_rs485,
    input wire rlcs_pkg::rlcs_cfg_s o_cfg,
    input wire logic                o_modbus_active,
    input wire logic                o_link_ready,
    input wire logic                o_comm_fault_trip,
    input wire logic                o_nv_wr
);
    // One clock domain, so one default clock and reset
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    a_nv_needs_write: assert property (
        o_nv_wr |-> $past(i_wr)) else $error("store write without a write");
    a_trip_sticks: assert property (
        o_comm_fault_trip |=> o_comm_fault_trip [*3]) else $error("trip fell");
    a_ready_no_trip: assert property (
        o_link_ready |-> !o_comm_fault_trip) else $error("ready while tripped");
    a_modbus_port_only: assert property (
        o_modbus_active |-> i_port_is_rs485 && o_cfg.modbus) else $error("modbus off port");
    a_cfg_frozen: assert property (
        o_link_ready |=> $stable(o_cfg)) else $error("settings moved without reset");
    a_station_range: assert property (
        o_link_ready |-> o_cfg.station <= (o_cfg.modbus ? MAX_STN_MB[7:0] : MAX_STN_NAT[7:0]))
        else $error("station out of range");
    a_modbus_format: assert property (
        o_link_ready && o_cfg.modbus |-> o_cfg.data_bits == MB_DATA_BITS)
        else $error("modbus data length");
    a_modbus_ignores: assert property (
        o_link_ready && o_cfg.modbus |-> o_cfg.retry_off && o_cfg.check_off
        && o_cfg.wait_off && o_cfg.term == TERM_NONE) else $error("native setting used");
    a_option_codes: assert property (
        o_link_ready |-> o_cfg.parity <= 2'h2 && o_cfg.term <= TERM_CRLF)
        else $error("option code out of range");
endmodule // rlcs_top_chk
bind rlcs_top rlcs_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_wr(i_wr),
    .i_port_is_rs485(i_port_is_rs485), .o_cfg(o_cfg), .o_modbus_active(o_modbus_active),
    .o_link_ready(o_link_ready), .o_comm_fault_trip(o_comm_fault_trip), .o_nv_wr(o_nv_wr));

// ### rlcs_top_tb.sv
// Self-checking bench for the link configuration block
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module rlcs_top_tb;
    import rlcs_pkg::*;
    logic        clk, rst_b, pwr, wr, rd, opt, net, p485, frm, err, rd_d;
    logic        ready, mbact, trip, nvwr;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, st, rt, pa, tm, exp_d;
    logic [15:0] q [$];
    rlcs_cfg_s   cfg;
    int          bad_count, compares, cyc, sp;
    // Legal speed codes, then one just-illegal value for each of the first eight settings
    logic [15:0] spd [0:7] = '{16'h0003, 16'h0006, 16'h000C, 16'h0018, 16'h0030,
                               16'h0060, 16'h00C0, 16'h0180};
    logic [15:0] ill [0:7] = '{16'h0020, 16'h0064, 16'h0005, 16'h0003, 16'h000B,
                               16'h2710, 16'h0097, 16'h0003};
    logic [15:0] ini [0:10] = '{INIT_STATION, INIT_SPEED, INIT_CHARFMT, INIT_PARITY,
        INIT_RETRY, INIT_CHECK, INIT_WAIT, INIT_TERM, INIT_NVSEL, INIT_PROTO, INIT_UGROUP};
    rlcs_top DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_power_up(pwr), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_option_present(opt),
        .i_net_mode(net), .i_port_is_rs485(p485), .i_rx_frame(frm), .i_rx_error(err),
        .o_cfg(cfg), .o_modbus_active(mbact), .o_link_ready(ready),
        .o_comm_fault_trip(trip), .o_nv_wr(nvwr), .o_tick_100ms());
    rlcs_host HOST (.i_ref_clk(clk), .o_rx_frame(frm), .o_rx_error(err));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Read data stands only the cycle after the strobe; hang guard too
    always @(posedge clk) begin
        if (rd_d) begin
            exp_d = q.pop_front();
            `CHK(rdata, exp_d)
        end
        rd_d <= rd;
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            bad_count++;
            results();
        end
    end
    // One strobe cycle; a read notes its expected data
    task automatic rw(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) q.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic reboot(input logic p);
        @(posedge clk);
        rst_b <= 1'b0;
        pwr <= p;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        pwr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {rst_b, wr, rd, opt, net, rd_d, addr, wdata} = '0;
        {pwr, p485} = 2'b11;
        {bad_count, compares, cyc} = '0;
        void'($urandom(54));
        reboot(1'b1);
        for (int i = 0; i < 11; i++) rw(1'b0, i[3:0], ini[i]);
        rw(1'b0, 4'hE, 16'h0000);
        st = 16'($urandom % 32);
        rt = 16'($urandom % 11);
        pa = 16'($urandom % 3);
        tm = 16'($urandom % 3);
        sp = int'($urandom % 8);
        rw(1'b1, ADDR_STATION, st);
        #1 `CHK(nvwr, 1'b1)
        `CHK(ready, 1'b0)
        rw(1'b1, ADDR_SPEED, spd[sp]);
        rw(1'b1, ADDR_RETRY, rt);
        rw(1'b1, ADDR_PARITY, pa);
        rw(1'b1, ADDR_TERM, tm);
        `CHK(cfg.station, 8'h00)
        reboot(1'b0);
        `CHK(cfg.station, st[7:0])
        `CHK(cfg.speed, rlcs_speed_e'(sp[2:0]))
        `CHK(cfg.retry, rt[3:0])
        `CHK(cfg.parity, pa[1:0])
        `CHK(cfg.term, tm[1:0])
        for (int i = 0; i < 8; i++) rw(1'b1, i[3:0], ill[i]);
        reboot(1'b0);
        `CHK(cfg.speed, RLCS_SPD_96)
        `CHK(cfg.parity, 2'h2)
        `CHK(cfg.term, TERM_CR)
        `CHK(cfg.retry, 4'h1)
        `CHK(cfg.wait_off, 1'b1)
        `CHK({cfg.station, cfg.modbus, cfg.check_zero}, 10'h001)
        rw(1'b1, ADDR_PROTO, 16'h0001);
        rw(1'b1, ADDR_STATION, 16'h00F7);
        reboot(1'b0);
        `CHK({cfg.station, mbact}, 9'h1EF)
        p485 <= 1'b0;
        #1 `CHK(mbact, 1'b0)
        rw(1'b1, ADDR_PROTO, 16'h0000);
        rw(1'b1, ADDR_NVSEL, 16'h0001);
        rw(1'b1, ADDR_STATION, 16'h0005);
        #1 `CHK(nvwr, 1'b0)
        rw(1'b0, ADDR_STATION, 16'h0005);
        reboot(1'b1);
        rw(1'b0, ADDR_STATION, 16'h00F7);
        rw(1'b1, ADDR_UGROUP, 16'h0001);
        rw(1'b1, ADDR_STATION, 16'h0003);
        rw(1'b0, ADDR_STATION, 16'h00F7);
        opt <= 1'b1;
        repeat (4) @(posedge clk);
        rw(1'b1, ADDR_NVSEL, 16'h0000);
        rw(1'b0, ADDR_NVSEL, 16'h0000);
        rw(1'b1, ADDR_UGROUP, 16'h0000);
        // network boot with interval 0 trips on traffic
        net <= 1'b1;
        reboot(1'b0);
        HOST.send(2);
        for (int n = 0; n < 12 && trip !== 1'b1; n++) @(posedge clk);
        `CHK({trip, ready}, 2'b10)
        // host disables the check before working
        rw(1'b1, ADDR_CHECK, VAL_9999);
        reboot(1'b0);
        HOST.send(9);
        repeat (12) @(posedge clk);
        `CHK({trip, ready}, 2'b01)
        results();
    end
endmodule // rlcs_top_tb

// ### rlcs_validate.sv
// Range check and default substitution for one link setting set
`timescale 1ns/10ps
module rlcs_validate (
    input  wire logic [15:0]        i_station,
    input  wire logic [15:0]        i_speed,
    input  wire logic [15:0]        i_charfmt,
    input  wire logic [15:0]        i_parity,
    input  wire logic [15:0]        i_retry,
    input  wire logic [15:0]        i_check,
    input  wire logic [15:0]        i_wait,
    input  wire logic [15:0]        i_term,
    input  wire logic [15:0]        i_proto,
    output rlcs_pkg::rlcs_cfg_s     o_cfg
);
    import rlcs_pkg::*;

    logic [15:0] stn;     // Validated station
    logic [15:0] cf;      // Validated char format
    logic [15:0] par;     // Validated parity
    logic [15:0] rty;     // Validated retry
    logic [15:0] chk;     // Validated check interval
    logic [15:0] wt;      // Validated wait
    logic [15:0] trm;     // Validated terminator
    logic        mb;      // Modbus selected

    // Fold every setting into a legal value
    always_comb begin
        o_cfg = '0;
        // RQ11: protocol select decode
        mb = (i_proto == 16'h0001);
        // RQ15: bad protocol falls back
        if (i_proto > 16'h0001) begin
            mb = 1'b0;
        end
        // RQ1: station range per protocol
        stn = (i_station <= (mb ? MAX_STN_MB : MAX_STN_NAT)) ? i_station : INIT_STATION;
        // RQ3: four legal format codes
        cf = (i_charfmt <= 16'h0001 || i_charfmt == CF_10 || i_charfmt == CF_11)
           ? i_charfmt : INIT_CHARFMT;
        // RQ4: three parity options
        par = (i_parity <= MAX_TRI) ? i_parity : INIT_PARITY;
        // RQ5: retry range plus 9999
        rty = (i_retry <= MAX_RETRY || i_retry == VAL_9999) ? i_retry : INIT_RETRY;
        // RQ7: check interval range
        chk = (i_check <= MAX_CHECK || i_check == VAL_9999) ? i_check : INIT_CHECK;
        // RQ8: wait range plus 9999
        wt = (i_wait <= MAX_WAIT || i_wait == VAL_9999) ? i_wait : INIT_WAIT;
        // RQ9: terminator three codes
        trm = (i_term <= MAX_TRI) ? i_term : INIT_TERM;
        // RQ13: Modbus ignores native settings
        if (mb) begin
            cf  = INIT_CHARFMT;
            rty = VAL_9999;
            chk = VAL_9999;
            wt  = VAL_9999;
            trm = {14'h0000, TERM_NONE};
        end
        o_cfg.station = stn[7:0];
        o_cfg.modbus  = mb;
        // RQ2: speed code to index
        if (i_speed == 16'h0003) begin
            o_cfg.speed = RLCS_SPD_3;
        end else if (i_speed == 16'h0006) begin
            o_cfg.speed = RLCS_SPD_6;
        end else if (i_speed == 16'h000C) begin
            o_cfg.speed = RLCS_SPD_12;
        end else if (i_speed == 16'h0018) begin
            o_cfg.speed = RLCS_SPD_24;
        end else if (i_speed == 16'h0030) begin
            o_cfg.speed = RLCS_SPD_48;
        end else if (i_speed == 16'h00C0) begin
            o_cfg.speed = RLCS_SPD_192;
        end else if (i_speed == 16'h0180) begin
            o_cfg.speed = RLCS_SPD_384;
        end else begin
            o_cfg.speed = RLCS_SPD_96;
        end
        // RQ12: Modbus fixes data, parity sets stop
        if (mb) begin
            o_cfg.data_bits = MB_DATA_BITS;
            o_cfg.stop_bits = (par == 16'h0000) ? 2'h2 : 2'h1;
        end else begin
            o_cfg.data_bits = cf[0] ? 4'h7 : 4'h8;
            o_cfg.stop_bits = (cf >= CF_10) ? 2'h2 : 2'h1;
        end
        o_cfg.parity       = par[1:0];
        o_cfg.retry_off    = (rty == VAL_9999);
        o_cfg.retry        = rty[3:0];
        o_cfg.check_off    = (chk == VAL_9999);
        o_cfg.check_zero   = (chk == 16'h0000);
        o_cfg.check_tenths = chk;
        o_cfg.wait_off     = (wt == VAL_9999);
        o_cfg.wait_ms      = wt[7:0];
        // RQ10: terminator code meaning
        o_cfg.term         = trm[1:0];
    end

endmodule // rlcs_validate
